// ### verilog/epa_pkg.sv
// Package for the expansion port pin assignment block: offsets, fields, resets, types.
// Assumes a single core clock and an Avalon-MM register bus.
package epa_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] EPA_IDX_LOW_DATA = 4'h1;
  localparam logic [3:0] EPA_IDX_LOW_DIR = 4'h3;
  localparam logic [3:0] EPA_IDX_CTL_DATA = 4'h8;
  localparam logic [3:0] EPA_IDX_CTL_DIR = 4'h9;
  localparam logic [3:0] EPA_IDX_ASSIGN = 4'hA;
  localparam logic [3:0] EPA_IDX_PIN_CFG = 4'hB;

  // Assignment register fields
  localparam int unsigned EPA_NO_DATA_ENABLE = 7;
  localparam int unsigned EPA_CLOCKGEN_TEST_ENABLE = 6;
  localparam int unsigned EPA_PIPE_STATUS_ENABLE = 5;
  localparam int unsigned EPA_NO_BUS_CLOCK = 4;
  localparam int unsigned EPA_LOW_STROBE_ENABLE = 3;
  localparam int unsigned EPA_READ_WRITE_ENABLE = 2;
  localparam int unsigned EPA_CALIBRATION_ENABLE = 1;
  localparam int unsigned EPA_DATA_ENABLE_SELECT = 0;
  localparam int unsigned EPA_PULLUP_BIT = 0;

  // Reset values
  localparam logic [7:0] EPA_ASSIGN_RST_NORM_EXP = 8'h00;
  localparam logic [7:0] EPA_ASSIGN_RST_SPECIAL = 8'h2C;
  localparam logic [7:0] EPA_ASSIGN_RST_PERIPH = 8'hD0;
  localparam logic [7:0] EPA_ASSIGN_RST_NORM_SINGLE = 8'h90;
  localparam logic [7:0] EPA_DATA_RST = 8'h00;
  localparam logic [7:0] EPA_DIR_RST = 8'h00;
  localparam logic EPA_PIN_CFG_RST = 1'b0;

  // Pin masks
  localparam logic [7:0] EPA_CTL_INPUT_ONLY = 8'h03;
  localparam logic [7:0] EPA_PULLUP_PINS = 8'h8F;
  localparam logic [7:0] EPA_ONCE_MASK = 8'hAD;

  typedef enum logic [2:0] {
    EPA_SPEC_SINGLE = 3'h0,
    EPA_SPEC_NARROW = 3'h1,
    EPA_PERIPH = 3'h2,
    EPA_SPEC_WIDE = 3'h3,
    EPA_NORM_SINGLE = 3'h4,
    EPA_NORM_NARROW = 3'h5,
    EPA_RESERVED = 3'h6,
    EPA_NORM_WIDE = 3'h7
  } epa_mode_t;

  typedef struct packed {
    logic single;
    logic expanded;
    logic normal;
    logic periph;
    logic narrow;
  } epa_flags_t;

  // Signals from the on-chip bus engine
  typedef struct packed {
    logic [7:0] addr_lo;
    logic [7:0] data_out;
    logic data_phase;
    logic data_drive;
    logic data_bus_enable;
    logic bus_clock;
    logic low_strobe;
    logic read_write;
    logic pipe_status_hi;
    logic pipe_status_lo;
    logic clockgen_test;
    logic cal_ref;
  } epa_bus_t;

  typedef struct packed {
    logic [7:0] lp_data;
    logic [7:0] lp_dir;
    logic [7:0] cp_data;
    logic [7:0] cp_dir;
    logic [7:0] assign_r;
    logic [7:0] seen;
    logic pull_on;
    logic [7:0] lp_s1;
    logic [7:0] lp_s2;
    logic [7:0] lp_s3;
    logic [7:0] lp_pin;
    logic [7:0] cp_s1;
    logic [7:0] cp_s2;
    logic [7:0] cp_s3;
    logic [7:0] cp_pin;
    logic waitreq;
    logic [7:0] rdata;
    logic ext_acc;
    logic [7:0] lp_out;
    logic [7:0] lp_oe_n;
    logic [7:0] cp_out;
    logic [7:0] cp_oe_n;
    logic [7:0] pullup_out;
  } epa_state_t;

endpackage

// ### verilog/epa_expansion_port.sv
// Expansion port pin assignment: low port and control port muxing with registers.
// Assumes an Avalon-MM master on the core clock and a bus engine feeding i_bus.
//
// Behaviour
// - Wide and peripheral modes mux address and data on low port; narrow only address.
// - Low port direction bit: 0 input, 1 output in general I/O; resets to 0.
// - Expanded and peripheral modes drop low port registers; accesses go external.
// - Control port registers drop out in peripheral, or expanded with emulation set.
// - Control pins 1 and 0 are inputs only, direction reads 0, levels readable.
// - One bit enables pull-ups on control pins 7,3,2,1,0 that are inputs.
// - A selected bus-control function overrides the pin's direction bit.
// - Assignment register resets to a mode-dependent pattern.
// - Peripheral mode: assignment register unreachable, test enable resets to one.
// - Bit 7 is data enable or inverted clock, else calibration or I/O.
// - Once-bits: normal modes accept one write, special ignore the first only.
// - Test enable never writable in normal modes; pipe status enable overrides it.
// - Pipe status enable in expanded modes drives queue state on bits 6 and 5.
// - No-bus-clock bit: once in normal single, anytime special single, else never.
// - Bus clock pin is input in peripheral mode, output elsewhere unless the no-bus-clock bit is set.
// - Special modes leave reset with bus-control functions and calibration as listed.
// - Unassigned control pins are general I/O; data register accessible whatever the assignment.
// - Low strobe enable drives bit 3 except in single chip or normal narrow.
// - Read/write enable drives bit 2 in expanded modes only.
// - Select bit chooses data enable (0) or inverted bus clock (1) on bit 7.
// - Port emulation in expanded mode moves control port registers off-chip.
`timescale 1ns/1ps
`default_nettype none
module epa_expansion_port
  import epa_pkg::*;
#(
  parameter int unsigned ADDR_W = 6
)
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire epa_mode_t i_mode,
  input wire logic i_port_emulation,
  input wire epa_bus_t i_bus,
  input wire logic [7:0] i_low_port_pins,
  input wire logic [7:0] i_control_port_pins,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_external_access,
  output logic [7:0] o_low_port_out,
  output logic [7:0] o_low_port_oe_n,
  output logic [7:0] o_control_port_out,
  output logic [7:0] o_control_port_oe_n,
  output logic [7:0] o_pullup_en
);

  if (ADDR_W < 6)
  begin : g_addr_check
    $error("ADDR_W must be at least 6");
  end

  function automatic epa_flags_t mode_flags(input epa_mode_t m);
    epa_flags_t f;
    f = '0;
    case (m)
      EPA_SPEC_SINGLE: f.single = 1'b1;
      EPA_SPEC_NARROW:
      begin
        f.expanded = 1'b1;
        f.narrow = 1'b1;
      end
      EPA_PERIPH: f.periph = 1'b1;
      EPA_SPEC_WIDE: f.expanded = 1'b1;
      EPA_NORM_NARROW:
      begin
        f.expanded = 1'b1;
        f.narrow = 1'b1;
        f.normal = 1'b1;
      end
      EPA_NORM_WIDE:
      begin
        f.expanded = 1'b1;
        f.normal = 1'b1;
      end
      default:
      begin
        f.single = 1'b1;
        f.normal = 1'b1;
      end
    endcase
    return f;
  endfunction

  function automatic logic known_idx(input logic [3:0] idx);
    return idx == EPA_IDX_LOW_DATA || idx == EPA_IDX_LOW_DIR || idx == EPA_IDX_CTL_DATA ||
      idx == EPA_IDX_CTL_DIR || idx == EPA_IDX_ASSIGN || idx == EPA_IDX_PIN_CFG;
  endfunction

  function automatic logic in_map(input logic [3:0] idx, input epa_flags_t f, input logic emul);
    logic r;
    r = 1'b0;
    case (idx)
      EPA_IDX_LOW_DATA, EPA_IDX_LOW_DIR: r = f.single;
      EPA_IDX_CTL_DATA, EPA_IDX_CTL_DIR: r = !f.periph && !(f.expanded && emul);
      EPA_IDX_ASSIGN, EPA_IDX_PIN_CFG: r = !f.periph;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] accept_mask(input epa_flags_t f, input logic [7:0] seen);
    logic [7:0] m;
    m = 8'h00;
    m = f.normal ? (EPA_ONCE_MASK & ~seen) : (EPA_ONCE_MASK & seen);
    m[EPA_CALIBRATION_ENABLE] = 1'b1;
    m[EPA_CLOCKGEN_TEST_ENABLE] = !f.normal && seen[EPA_CLOCKGEN_TEST_ENABLE];
    m[EPA_NO_BUS_CLOCK] = f.single && (!f.normal || !seen[EPA_NO_BUS_CLOCK]);
    return m;
  endfunction

  function automatic logic [7:0] assign_reset(input epa_flags_t f);
    logic [7:0] v;
    v = EPA_ASSIGN_RST_NORM_EXP;
    if (f.periph)
      v = EPA_ASSIGN_RST_PERIPH;
    else if (!f.normal)
      v = EPA_ASSIGN_RST_SPECIAL;
    else if (f.single)
      v = EPA_ASSIGN_RST_NORM_SINGLE;
    return v;
  endfunction

  epa_state_t q;
  epa_state_t d;
  epa_state_t rst_val;
  epa_flags_t flags;
  logic [3:0] idx;
  logic aligned;
  logic present;
  logic go;
  logic wr;
  logic [7:0] wd;
  logic [7:0] amask;
  logic [7:0] agree_lp;
  logic [7:0] agree_cp;
  logic [7:0] cp_o;
  logic [7:0] cp_e;
  logic [7:0] lp_o;
  logic [7:0] lp_e;
  logic [7:0] a;

  assign flags = mode_flags(i_mode);
  assign idx = i_avs_address[5:2];
  assign aligned = (i_avs_address[1:0] == 2'h0) && ((i_avs_address >> 6) == '0);
  assign present = aligned && in_map(idx, flags, i_port_emulation);
  assign go = (i_avs_read || i_avs_write) && !q.waitreq;
  assign wr = go && i_avs_write && i_avs_byteenable[0] && present;
  assign wd = i_avs_writedata[7:0];
  assign amask = accept_mask(flags, q.seen);
  assign a = q.assign_r;

  always_comb
  begin
    rst_val = '0;
    rst_val.assign_r = assign_reset(flags);
    rst_val.lp_data = EPA_DATA_RST;
    rst_val.lp_dir = EPA_DIR_RST;
    rst_val.cp_data = EPA_DATA_RST;
    rst_val.cp_dir = EPA_DIR_RST;
    rst_val.pull_on = EPA_PIN_CFG_RST;
    rst_val.waitreq = 1'b1;
    rst_val.lp_oe_n = 8'hFF;
    rst_val.cp_oe_n = 8'hFF;
  end

  always_comb
  begin
    d = q;
    agree_lp = ~(q.lp_s2 ^ q.lp_s3);
    agree_cp = ~(q.cp_s2 ^ q.cp_s3);
    d.lp_s1 = i_low_port_pins;
    d.lp_s2 = q.lp_s1;
    d.lp_s3 = q.lp_s2;
    d.lp_pin = (agree_lp & q.lp_s3) | (~agree_lp & q.lp_pin);
    d.cp_s1 = i_control_port_pins;
    d.cp_s2 = q.cp_s1;
    d.cp_s3 = q.cp_s2;
    d.cp_pin = (agree_cp & q.cp_s3) | (~agree_cp & q.cp_pin);
    d.waitreq = !((i_avs_read || i_avs_write) && q.waitreq);
    d.ext_acc = go && aligned && known_idx(idx) && !present;
    if ((i_avs_read || i_avs_write) && q.waitreq)
    begin
      d.rdata = 8'h00;
      if (i_avs_read && present)
      begin
        case (idx)
          EPA_IDX_LOW_DATA: d.rdata = (q.lp_dir & q.lp_data) | (~q.lp_dir & q.lp_pin);
          EPA_IDX_LOW_DIR: d.rdata = q.lp_dir;
          EPA_IDX_CTL_DATA: d.rdata = (q.cp_dir & q.cp_data) | (~q.cp_dir & q.cp_pin);
          EPA_IDX_CTL_DIR: d.rdata = q.cp_dir;
          EPA_IDX_ASSIGN: d.rdata = q.assign_r;
          EPA_IDX_PIN_CFG: d.rdata = {7'h00, q.pull_on};
          default: d.rdata = 8'h00;
        endcase
      end
    end
    if (wr)
    begin
      case (idx)
        EPA_IDX_LOW_DATA: d.lp_data = wd;
        EPA_IDX_LOW_DIR: d.lp_dir = wd;
        EPA_IDX_CTL_DATA: d.cp_data = wd;
        EPA_IDX_CTL_DIR: d.cp_dir = wd & ~EPA_CTL_INPUT_ONLY;
        EPA_IDX_ASSIGN:
        begin
          d.assign_r = (q.assign_r & ~amask) | (wd & amask);
          d.seen = 8'hFF;
        end
        EPA_IDX_PIN_CFG: d.pull_on = wd[EPA_PULLUP_BIT];
        default: d.seen = q.seen;
      endcase
    end
    cp_o = q.cp_data;
    cp_e = q.cp_dir;
    if (flags.expanded && !a[EPA_NO_DATA_ENABLE])
    begin
      cp_o[7] = a[EPA_DATA_ENABLE_SELECT] ? !i_bus.bus_clock : i_bus.data_bus_enable;
      cp_e[7] = 1'b1;
    end
    else if (a[EPA_CALIBRATION_ENABLE])
    begin
      cp_o[7] = i_bus.cal_ref;
      cp_e[7] = 1'b1;
    end
    if (a[EPA_PIPE_STATUS_ENABLE] && flags.expanded)
    begin
      cp_o[6] = i_bus.pipe_status_hi;
      cp_o[5] = i_bus.pipe_status_lo;
      cp_e[6] = 1'b1;
      cp_e[5] = 1'b1;
    end
    else if (a[EPA_CLOCKGEN_TEST_ENABLE] && !flags.single && !(flags.normal && flags.expanded))
    begin
      cp_o[6] = i_bus.clockgen_test;
      cp_e[6] = 1'b1;
    end
    if (flags.periph)
      cp_e[4] = 1'b0;
    else if (!a[EPA_NO_BUS_CLOCK])
    begin
      cp_o[4] = i_bus.bus_clock;
      cp_e[4] = 1'b1;
    end
    if (a[EPA_LOW_STROBE_ENABLE] && !flags.single && !(flags.normal && flags.narrow))
    begin
      cp_o[3] = i_bus.low_strobe;
      cp_e[3] = 1'b1;
    end
    if (a[EPA_READ_WRITE_ENABLE] && flags.expanded)
    begin
      cp_o[2] = i_bus.read_write;
      cp_e[2] = 1'b1;
    end
    cp_e[1:0] = 2'b00;
    d.cp_out = cp_o;
    d.cp_oe_n = ~cp_e;
    d.pullup_out = {8{q.pull_on}} & EPA_PULLUP_PINS & ~cp_e;
    lp_o = q.lp_data;
    lp_e = q.lp_dir;
    if (flags.expanded && flags.narrow)
    begin
      lp_o = i_bus.addr_lo;
      lp_e = 8'hFF;
    end
    else if (!flags.single)
    begin
      lp_o = i_bus.data_phase ? i_bus.data_out : i_bus.addr_lo;
      lp_e = i_bus.data_phase ? {8{i_bus.data_drive}} : {8{!flags.periph}};
    end
    d.lp_out = lp_o;
    d.lp_oe_n = ~lp_e;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      q <= rst_val;
    else if (i_clk_en)
      q <= d;
  end

  assign o_avs_readdata = {24'h000000, q.rdata};
  assign o_avs_waitrequest = q.waitreq;
  assign o_external_access = q.ext_acc;
  assign o_low_port_out = q.lp_out;
  assign o_low_port_oe_n = q.lp_oe_n;
  assign o_control_port_out = q.cp_out;
  assign o_control_port_oe_n = q.cp_oe_n;
  assign o_pullup_en = q.pullup_out;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  int_pins_input_a: assert property (o_control_port_oe_n[1:0] == 2'b11 && q.cp_dir[1:0] == 2'b00)
    else $error("interrupt pins driven or direction bits set");
  low_gpio_dir_a: assert property (i_clk_en && flags.single |=> o_low_port_oe_n == ~$past(q.lp_dir))
    else $error("low port direction not applied");
  narrow_addr_a: assert property (i_clk_en && flags.expanded && flags.narrow |=>
    o_low_port_out == $past(i_bus.addr_lo) && o_low_port_oe_n == 8'h00)
    else $error("narrow mode low port not address");
  bus_clk_pin_a: assert property (i_clk_en && flags.periph |=> o_control_port_oe_n[4])
    else $error("bus clock pin driven in peripheral mode");
  ext_access_a: assert property (i_clk_en && go && aligned && idx == EPA_IDX_LOW_DIR &&
    !flags.single |=> o_external_access ##1 !o_external_access || !i_clk_en)
    else $error("removed register access not external");
  once_normal_a: assert property (i_clk_en && wr && idx == EPA_IDX_ASSIGN && flags.normal &&
    q.seen[EPA_NO_DATA_ENABLE] |=> $stable(q.assign_r[EPA_NO_DATA_ENABLE]))
    else $error("once bit written twice");
  test_en_normal_a: assert property (i_clk_en && wr && idx == EPA_IDX_ASSIGN && flags.normal
    |=> $stable(q.assign_r[EPA_CLOCKGEN_TEST_ENABLE]))
    else $error("test enable written in normal mode");
  reset_pattern_a: assert property ($fell(i_rst) && $past(i_mode) == EPA_PERIPH |->
    q.assign_r == EPA_ASSIGN_RST_PERIPH)
    else $error("peripheral reset pattern wrong");
  strobe_override_a: assert property (i_clk_en && a[EPA_LOW_STROBE_ENABLE] && flags.expanded &&
    !flags.normal |=> !o_control_port_oe_n[3] && o_control_port_out[3] == $past(i_bus.low_strobe))
    else $error("low strobe not overriding pin");
  pullup_input_a: assert property (o_pullup_en[6:4] == 3'b000 &&
    (o_pullup_en & ~o_control_port_oe_n) == 8'h00)
    else $error("pull-up on driven or unlisted pin");
  wait_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en
    |=> !o_avs_waitrequest)
    else $error("waitrequest did not drop");
  pipe_out_a: assert property (i_clk_en && flags.expanded && a[EPA_PIPE_STATUS_ENABLE]
    |=> o_control_port_oe_n[6:5] == 2'b00 &&
    o_control_port_out[6] == $past(i_bus.pipe_status_hi) &&
    o_control_port_out[5] == $past(i_bus.pipe_status_lo))
    else $error("pipe status pins not driven");
  data_en_pin_a: assert property (i_clk_en && flags.expanded && !a[EPA_NO_DATA_ENABLE] &&
    !a[EPA_DATA_ENABLE_SELECT] |=> !o_control_port_oe_n[7] &&
    o_control_port_out[7] == $past(i_bus.data_bus_enable))
    else $error("data enable not on bit 7");
  inv_clock_pin_a: assert property (i_clk_en && flags.expanded && !a[EPA_NO_DATA_ENABLE] &&
    a[EPA_DATA_ENABLE_SELECT] |=> !o_control_port_oe_n[7] &&
    o_control_port_out[7] == !$past(i_bus.bus_clock))
    else $error("inverted bus clock not on bit 7");
  cal_pin_a: assert property (i_clk_en && flags.single && a[EPA_CALIBRATION_ENABLE] |=>
    !o_control_port_oe_n[7] && o_control_port_out[7] == $past(i_bus.cal_ref))
    else $error("calibration output not on bit 7");
  narrow_strobe_a: assert property (i_clk_en && flags.normal && flags.narrow &&
    !q.cp_dir[3] |=> o_control_port_oe_n[3])
    else $error("low strobe driven in normal narrow mode");
  single_rw_a: assert property (i_clk_en && flags.single && !q.cp_dir[2] |=>
    o_control_port_oe_n[2])
    else $error("read/write driven in single chip mode");
  bus_clk_out_a: assert property (i_clk_en && !flags.periph && !a[EPA_NO_BUS_CLOCK] |=>
    !o_control_port_oe_n[4] && o_control_port_out[4] == $past(i_bus.bus_clock))
    else $error("bus clock not driven on bit 4");
  no_clk_lock_a: assert property (i_clk_en && wr && idx == EPA_IDX_ASSIGN && !flags.single
    |=> $stable(q.assign_r[EPA_NO_BUS_CLOCK]))
    else $error("no-bus-clock bit written outside single chip");
  low_removed_a: assert property (i_clk_en && go && i_avs_write &&
    idx == EPA_IDX_LOW_DATA && !flags.single |=> $stable(q.lp_data))
    else $error("removed low port register written");
  special_rst_a: assert property ($fell(i_rst) && !$past(flags.normal) &&
    !$past(flags.periph) |-> q.assign_r == EPA_ASSIGN_RST_SPECIAL)
    else $error("special reset pattern wrong");

  assign_write_c: cover property (wr && idx == EPA_IDX_ASSIGN);
  ext_access_c: cover property (o_external_access);
  pipe_out_c: cover property (flags.expanded && a[EPA_PIPE_STATUS_ENABLE] && !o_control_port_oe_n[5]);
  special_second_c: cover property (wr && idx == EPA_IDX_ASSIGN && !flags.normal && q.seen[0]);
  cal_out_c: cover property (flags.single && a[EPA_CALIBRATION_ENABLE] && !o_control_port_oe_n[7]);

endmodule
`default_nettype wire

// ### bench/epa_ext_bus.sv
// External memories and peripherals seen at one port's pins.
// Assumes the block's registered pin data and active-low enables.
`timescale 1ns/1ps
`default_nettype none
module epa_ext_bus
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe_n,
  input wire logic [7:0] i_pullup,
  input wire logic [7:0] i_ext_drive,
  input wire logic [7:0] i_ext_data,
  output logic [7:0] o_pins
);
  logic [7:0] last_q = 8'h00;
  // Released lines take the external data, else the pull-up level, else flip every cycle
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!i_oe_n[i])
        o_pins[i] = i_out[i];
      else if (i_ext_drive[i])
        o_pins[i] = i_ext_data[i];
      else if (i_pullup[i])
        o_pins[i] = 1'b1;
      else
        o_pins[i] = ~last_q[i];
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    last_q <= o_pins;
  end
endmodule
`default_nettype wire

// ### bench/test_expansion_port_pin_assignment.sv
// Self-checking bench for the expansion port pin assignment block.
// Assumes the port block, two external bus models and one 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_expansion_port_pin_assignment;
  import epa_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  epa_mode_t i_mode = EPA_NORM_SINGLE;
  logic i_port_emulation = 1'b0;
  epa_bus_t i_bus = '0;
  logic [5:0] i_avs_address = 6'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic i_clk_en = 1'b1;
  logic [3:0] i_avs_byteenable = 4'h1;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic o_external_access;
  logic [7:0] lp_out, lp_oe_n, cp_out, cp_oe_n, pull_en, lp_pins, cp_pins;
  int fails = 0;
  int total_checks = 0;
  logic ext_seen;
  logic [7:0] d;

  initial
  begin
    forever #2 i_core_clk = ~i_core_clk;
  end

  epa_expansion_port dut_u
  (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_mode(i_mode),
    .i_port_emulation(i_port_emulation), .i_bus(i_bus), .i_low_port_pins(lp_pins),
    .i_control_port_pins(cp_pins), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_external_access(o_external_access),
    .o_low_port_out(lp_out), .o_low_port_oe_n(lp_oe_n), .o_control_port_out(cp_out),
    .o_control_port_oe_n(cp_oe_n), .o_pullup_en(pull_en)
  );
  epa_ext_bus lp_u (.i_core_clk(i_core_clk), .i_out(lp_out), .i_oe_n(lp_oe_n),
    .i_pullup(8'h00), .i_ext_drive(8'hFF), .i_ext_data(8'h3C), .o_pins(lp_pins));
  epa_ext_bus cp_u (.i_core_clk(i_core_clk), .i_out(cp_out), .i_oe_n(cp_oe_n),
    .i_pullup(pull_en), .i_ext_drive(8'hFF), .i_ext_data(8'h5E), .o_pins(cp_pins));

  task automatic test_done();
    begin
      if (fails == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      total_checks++;
      if (got !== exp)
      begin
        fails++;
        $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // One register access; waits for waitrequest low, notes the external pulse
  task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] wd);
    int n;
    begin
      n = 0;
      @(posedge i_core_clk);
      i_avs_address <= a;
      i_avs_writedata <= {24'h000000, wd};
      i_avs_write <= wr;
      i_avs_read <= !wr;
      do
      begin
        @(posedge i_core_clk);
        n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 50);
      if (o_avs_waitrequest !== 1'b0)
      begin
        fails++;
        test_done();
      end
      else
      begin
        d = o_avs_readdata[7:0];
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(negedge i_core_clk);
        ext_seen = o_external_access;
        @(posedge i_core_clk);
      end
    end
  endtask

  task automatic rst(input epa_mode_t m);
    begin
      @(posedge i_core_clk);
      i_mode <= m;
      i_rst <= 1'b1;
      repeat (12) @(posedge i_core_clk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_core_clk);
    end
  endtask

  task automatic settle();
    begin
      repeat (5) @(posedge i_core_clk);
      @(negedge i_core_clk);
    end
  endtask

  task automatic t_reset_values();
    logic [7:0] tbl [8];
    begin
      tbl = '{8'h2C, 8'h2C, 8'h00, 8'h2C, 8'h90, 8'h00, 8'h00, 8'h00};
      for (logic [3:0] k = 0; k < 8; k++)
      begin
        if (k == 6)
          continue;
        rst(epa_mode_t'(k[2:0]));
        acc(1'b0, 6'h28, 8'h00);
        chk("assign_rst", tbl[k], d);
        chk("assign_ext", (k == 2), ext_seen);
      end
    end
  endtask

  task automatic t_gpio();
    begin
      rst(EPA_NORM_SINGLE);
      settle();
      chk("lp_oe_rst", 8'hFF, lp_oe_n);
      acc(1'b1, 6'h0C, 8'hF0);
      acc(1'b1, 6'h04, 8'hA5);
      settle();
      chk("lp_oe", 8'h0F, lp_oe_n);
      chk("lp_out", 8'hA0, lp_out & 8'hF0);
      acc(1'b0, 6'h04, 8'h00);
      chk("lp_rd", 8'hAC, d);
      chk("lp_ext", 1'b0, ext_seen);
      acc(1'b0, 6'h20, 8'h00);
      chk("cp_rd", 8'h5E, d);
      acc(1'b1, 6'h24, 8'hFF);
      acc(1'b0, 6'h24, 8'h00);
      chk("cp_dir", 8'hFC, d);
      acc(1'b1, 6'h20, 8'hA5);
      acc(1'b1, 6'h2C, 8'h01);
      settle();
      chk("cp_oe", 8'h03, cp_oe_n);
      chk("cp_out", 8'hA4, cp_out & 8'hFC);
      chk("pull_out", 8'h03, pull_en);
      acc(1'b1, 6'h24, 8'h00);
      settle();
      chk("pull_in", 8'h8F, pull_en);
    end
  endtask

  task automatic t_once_normal();
    begin
      rst(EPA_NORM_SINGLE);
      acc(1'b1, 6'h28, 8'h00);
      acc(1'b0, 6'h28, 8'h00);
      chk("once_1st", 8'h00, d);
      acc(1'b1, 6'h28, 8'hFF);
      acc(1'b0, 6'h28, 8'h00);
      chk("once_2nd", 8'h02, d);
      i_bus <= '{cal_ref:1'b1, default:'0};
      settle();
      chk("cal_out", 2'b01, {cp_oe_n[7], cp_out[7]});
    end
  endtask

  task automatic t_special();
    begin
      rst(EPA_SPEC_WIDE);
      i_bus <= '{pipe_status_hi:1'b1, low_strobe:1'b1, data_bus_enable:1'b1, default:'0};
      settle();
      chk("sp_out", 8'hC8, cp_out & 8'hFC);
      chk("sp_oe", 8'h00, cp_oe_n & 8'hFC);
      acc(1'b1, 6'h28, 8'h01);
      acc(1'b0, 6'h28, 8'h00);
      chk("sp_1st", 8'h2C, d);
      acc(1'b1, 6'h28, 8'h2D);
      acc(1'b0, 6'h28, 8'h00);
      chk("sp_2nd", 8'h2D, d);
      i_bus <= '0;
      settle();
      chk("sp_nclk", 1'b1, cp_out[7]);
    end
  endtask

  task automatic t_expanded();
    begin
      rst(EPA_NORM_WIDE);
      i_bus <= '{addr_lo:8'h5A, bus_clock:1'b1, default:'0};
      settle();
      chk("ad_out", 8'h5A, lp_out);
      chk("ad_oe", 8'h00, lp_oe_n);
      chk("ne_out", 8'h10, cp_out & 8'h90);
      chk("ne_oe", 8'h00, cp_oe_n & 8'h90);
      @(posedge i_core_clk);
      i_bus <= '{data_phase:1'b1, data_drive:1'b1, data_out:8'hC3, default:'0};
      settle();
      chk("dt_out", 8'hC3, lp_out);
      @(posedge i_core_clk);
      i_bus <= '{data_phase:1'b1, default:'0};
      settle();
      chk("dt_rel", 8'hFF, lp_oe_n);
      acc(1'b0, 6'h04, 8'h00);
      chk("lp_gone", 1'b1, ext_seen);
      acc(1'b0, 6'h20, 8'h00);
      chk("cp_here", 1'b0, ext_seen);
      i_port_emulation <= 1'b1;
      acc(1'b0, 6'h24, 8'h00);
      chk("cp_emul", 1'b1, ext_seen);
      i_port_emulation <= 1'b0;
      acc(1'b1, 6'h28, 8'h0C);
      i_bus <= '{low_strobe:1'b1, read_write:1'b1, default:'0};
      settle();
      chk("str_out", 8'h0C, cp_out & 8'h0C);
      chk("str_oe", 8'h00, cp_oe_n & 8'h0C);
      rst(EPA_NORM_NARROW);
      acc(1'b1, 6'h28, 8'h08);
      i_bus <= '{addr_lo:8'h33, low_strobe:1'b1, default:'0};
      settle();
      chk("nr_addr", 8'h33, lp_out);
      chk("nr_str", 1'b1, cp_oe_n[3]);
    end
  endtask

  task automatic t_periph();
    begin
      rst(EPA_PERIPH);
      i_bus <= '{clockgen_test:1'b1, default:'0};
      settle();
      chk("pe_clk", 1'b1, cp_oe_n[4]);
      chk("pe_test", 2'b01, {cp_oe_n[6], cp_out[6]});
      acc(1'b0, 6'h20, 8'h00);
      chk("pe_cp", 1'b1, ext_seen);
      acc(1'b1, 6'h28, 8'h00);
      chk("pe_wr", 1'b1, ext_seen);
    end
  endtask

  // Byte enable off ignores a write; clock enable low freezes the pins
  task automatic t_freeze();
    begin
      rst(EPA_NORM_WIDE);
      i_avs_byteenable <= 4'h0;
      i_bus <= '{addr_lo:8'h5A, default:'0};
      acc(1'b1, 6'h28, 8'h0C);
      i_avs_byteenable <= 4'h1;
      acc(1'b0, 6'h28, 8'h00);
      chk("be_off", 8'h00, d);
      acc(1'b1, 6'h28, 8'h0C);
      acc(1'b0, 6'h28, 8'h00);
      chk("be_on", 8'h0C, d);
      i_clk_en <= 1'b0;
      i_bus <= '{addr_lo:8'h96, default:'0};
      settle();
      chk("frz_out", 8'h5A, lp_out);
      @(posedge i_core_clk);
      i_clk_en <= 1'b1;
      settle();
      chk("run_out", 8'h96, lp_out);
    end
  endtask

  initial
  begin
    t_reset_values();
    t_gpio();
    t_once_normal();
    t_special();
    t_expanded();
    t_periph();
    t_freeze();
    test_done();
  end
endmodule
`default_nettype wire
